/* rtl/cxa_unit.sv */
// cpu exception acceptance: ranking, vectoring, event codes, return
//
// Notes on behaviour
// RULE1: dma interrupts level 4, codes 640..6c0
// RULE2: fifo uart codes 700, 720, 740, 760
// RULE3: host bridge codes a00..a20 as listed
// RULE4: rank by level, then order; lower wins
// RULE5: reset goes a0000000, others vbr plus offset
// RULE6: resets/general code to exception_event_register, interrupts interrupt_event_register
// RULE7: external level read from four level pins
// RULE8: user break jumps dbr if user_break_debug_enable, else vbr+100
// RULE9: interrupt priority levels are software programmable
// RULE10: five decode exceptions share one priority
// RULE11: general exceptions accepted in program order
// RULE12: block bit clear accepts exceptions and interrupts
// RULE13: exception with block set forces manual reset; a user break under block is taken as a plain branch
// RULE14: ordinary interrupt waits while block bit set
// RULE15: nmi under block pends or accepts per setting
// RULE16: handler saves spc/ssr then clears block bit
// RULE17: return copies spc to pc, ssr to sr
// RULE18: software sets block before restoring and returning
// RULE19: reset entry clears vbr, sets md rb bl, mask
// RULE20: accepted non-reset exception saves pc and sr
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module cxa_unit #(
  parameter int NLVL = 16 // interrupt levels, must be 16
) (
  input  wire logic        clk_sys_in,       // cpu clock
  input  wire logic        arst_n_in,        // power-on reset, low
  input  wire logic        mrst_req_in,      // manual reset request
  input  wire logic        gen_exc_in,       // general exception seen
  input  wire logic [11:0] gen_code_in,      // its exception code
  input  wire logic [31:0] gen_pc_in,        // pc of faulting instr
  input  wire logic        ubrk_in,          // user break request
  input  wire logic        nmi_in,           // nonmaskable interrupt
  input  wire logic [3:0]  ext_irq_level_pins_in, // external level
  input  wire logic [16:0] periph_irq_in,    // peripheral sources
  input  wire logic        rte_in,           // return executed
  input  wire logic [31:0] cur_pc_in,        // next pc of pipeline
  input  wire logic [3:0]  reg_addr_in,      // register address
  input  wire logic [31:0] reg_wdata_in,     // register write data
  input  wire logic        reg_wr_in,        // write strobe
  input  wire logic        reg_rd_in,        // read strobe
  output logic      [31:0] reg_rdata_out,    // read data, next cycle
  output logic             branch_out,       // one-cycle redirect
  output logic      [31:0] branch_pc_out,    // redirect target
  output logic             mrst_out,         // modules to manual reset
  output logic      [31:0] status_register_out // live sr
);
  // elaboration-time guard: the ranking logic serves 16 levels only
  if (NLVL != 16) begin : g_nlvl_check
    $error("cxa_unit: NLVL must be 16");
  end

  logic [31:0] status_register_r;        // sr
  logic [31:0] vector_base_register_r;   // vbr
  logic [31:0] saved_program_counter_r;  // spc
  logic [31:0] saved_status_register_r;  // ssr
  logic [11:0] exception_event_register_r; // exception_event_register
  logic [11:0] interrupt_event_register_r; // interrupt_event_register
  logic [31:0] debug_base_register_r;    // dbr
  logic [1:0]  ctrl_r;                   // user_break_debug_enable and nmi-under-block
  logic [67:0] prio_r;                   // 4-bit level per source
  logic [31:0] reg_rdata_r;              // read data
  logic        branch_r;                 // redirect pulse
  logic [31:0] branch_pc_r;              // redirect target
  logic        mrst_r;                   // manual reset pulse
  logic [31:0] pc_r;                     // last pc handed out
  cxa_pkg::cxa_state_t state_r;          // acceptance state
  cxa_pkg::cxa_state_t state_nxt;

  // per-source codes, index order fixes order within a level
  function automatic logic [11:0] per_code(input int i);
    case (i)
      0:       per_code = cxa_pkg::CODE_DMA_TRANSFER_END_CH0; // [RULE1]
      1:       per_code = cxa_pkg::CODE_DMA_TRANSFER_END_CH1;
      2:       per_code = cxa_pkg::CODE_DMA_TRANSFER_END_CH2;
      3:       per_code = cxa_pkg::CODE_DMA_TRANSFER_END_CH3;
      4:       per_code = cxa_pkg::CODE_DMA_ADDRESS_FAULT;
      5:       per_code = cxa_pkg::CODE_UERI;  // [RULE2]
      6:       per_code = cxa_pkg::CODE_URXI;
      7:       per_code = cxa_pkg::CODE_UBRI;
      8:       per_code = cxa_pkg::CODE_UTXI;
      9:       per_code = cxa_pkg::CODE_HSERR; // [RULE3]
      10:      per_code = cxa_pkg::CODE_HERR;
      11:      per_code = cxa_pkg::CODE_HPDN;
      12:      per_code = cxa_pkg::CODE_HPUP;
      13:      per_code = cxa_pkg::CODE_HDMA0;
      14:      per_code = cxa_pkg::CODE_HDMA1;
      15:      per_code = cxa_pkg::CODE_HDMA2;
      default: per_code = cxa_pkg::CODE_HDMA3;
    endcase
  endfunction : per_code

  // block bit and interrupt mask views
  logic       bl;
  logic [3:0] imask;
  assign bl    = status_register_r[cxa_pkg::SR_BL];
  assign imask = status_register_r[cxa_pkg::SR_IMSK_LO +: 4];

  // interrupt ranking: highest level wins, lower index on a tie
  logic [3:0]  int_lvl;   // winning level, 0 means none
  logic [11:0] int_code;  // winning code
  always_comb begin
    int_lvl  = 4'h0;
    int_code = 12'h000;
    // external level pins: level 15 is pin value 0 [RULE7]
    if (ext_irq_level_pins_in != 4'hf) begin
      int_lvl  = 4'hf - ext_irq_level_pins_in;
      int_code = 12'(cxa_pkg::CODE_IRL_BASE
                 + {3'h0, ext_irq_level_pins_in, 5'h00});
    end
    // programmable level per peripheral source [RULE9] [RULE4]
    for (int i = 0; i < cxa_pkg::NPER; i++) begin
      if (periph_irq_in[i] && prio_r[i*4 +: 4] > int_lvl) begin
        int_lvl  = prio_r[i*4 +: 4];
        int_code = per_code(i);
      end
    end
  end

  // acceptance conditions
  logic int_take;   // ordinary interrupt accepted
  logic nmi_take;   // nmi accepted
  logic exc_any;    // general exception or user break present
  assign int_take = (int_lvl > imask) && !bl; // [RULE12] [RULE14]
  assign nmi_take = nmi_in && (!bl || ctrl_r[cxa_pkg::CTRL_NMIBL]);
  assign exc_any  = gen_exc_in || ubrk_in;

  // sequencer: a pulse of take follows each reset, exception, accepted interrupt or return request seen in idle
  always_comb begin
    state_nxt = cxa_pkg::CXA_IDLE;
    case (state_r)
      cxa_pkg::CXA_IDLE: begin
        if (mrst_req_in || exc_any || nmi_take || int_take
            || rte_in) begin
          state_nxt = cxa_pkg::CXA_TAKE;
        end
      end
      cxa_pkg::CXA_TAKE: state_nxt = cxa_pkg::CXA_IDLE;
      default:           state_nxt = cxa_pkg::CXA_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= cxa_pkg::CXA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // main acceptance: one event per cycle, priority reset > general
  // exception > user break > nmi > interrupt; return lowest
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // power-on entry [RULE19]
      status_register_r          <= cxa_pkg::SR_RESET;
      vector_base_register_r     <= cxa_pkg::VBR_RESET;
      saved_program_counter_r    <= 32'h0000_0000;
      saved_status_register_r    <= 32'h0000_0000;
      exception_event_register_r <= cxa_pkg::CODE_POR;
      interrupt_event_register_r <= 12'h000;
      branch_r                   <= 1'b0;
      branch_pc_r                <= cxa_pkg::RESET_ADDR;
      mrst_r                     <= 1'b0;
      pc_r                       <= cxa_pkg::RESET_ADDR;
    end else begin
      branch_r <= 1'b0;
      mrst_r   <= 1'b0;
      if (mrst_req_in || (gen_exc_in && bl)) begin
        // manual reset, or any non-break exception under block
        status_register_r          <= cxa_pkg::SR_RESET; // [RULE19]
        vector_base_register_r     <= cxa_pkg::VBR_RESET;
        exception_event_register_r <= cxa_pkg::CODE_MRST; // [RULE6]
        mrst_r                     <= 1'b1;               // [RULE13]
        branch_r                   <= 1'b1;
        branch_pc_r                <= cxa_pkg::RESET_ADDR; // [RULE5]
        pc_r                       <= cxa_pkg::RESET_ADDR;
      end else if (gen_exc_in) begin
        // pipeline reports oldest instruction first [RULE11]
        // decode-class codes come singly [RULE10]
        saved_program_counter_r    <= gen_pc_in;         // [RULE20]
        saved_status_register_r    <= status_register_r;
        exception_event_register_r <= gen_code_in;       // [RULE6]
        status_register_r[cxa_pkg::SR_BL] <= 1'b1;
        status_register_r[cxa_pkg::SR_MD] <= 1'b1;
        status_register_r[cxa_pkg::SR_RB] <= 1'b1;
        branch_r                   <= 1'b1;
        branch_pc_r                <= vector_base_register_r
                                      + cxa_pkg::GEN_OFFSET; // [RULE5]
        pc_r                       <= vector_base_register_r
                                      + cxa_pkg::GEN_OFFSET;
      end else if (ubrk_in) begin
        saved_program_counter_r    <= cur_pc_in;         // [RULE20]
        saved_status_register_r    <= status_register_r;
        exception_event_register_r <= cxa_pkg::CODE_UBRK;
        status_register_r[cxa_pkg::SR_BL] <= 1'b1;
        status_register_r[cxa_pkg::SR_MD] <= 1'b1;
        status_register_r[cxa_pkg::SR_RB] <= 1'b1;
        branch_r                   <= 1'b1;
        if (ctrl_r[cxa_pkg::CTRL_USER_BREAK_DEBUG_ENABLE]) begin
          branch_pc_r <= debug_base_register_r;           // [RULE8]
          pc_r        <= debug_base_register_r;
        end else begin
          branch_pc_r <= vector_base_register_r + cxa_pkg::UBRK_OFFSET;
          pc_r        <= vector_base_register_r + cxa_pkg::UBRK_OFFSET;
        end
      end else if (nmi_take || int_take) begin
        // interrupt entry [RULE15] [RULE12]
        saved_program_counter_r    <= cur_pc_in;         // [RULE20]
        saved_status_register_r    <= status_register_r;
        interrupt_event_register_r <= nmi_take ? cxa_pkg::CODE_NMI
                                               : int_code; // [RULE6]
        status_register_r[cxa_pkg::SR_BL] <= 1'b1;
        status_register_r[cxa_pkg::SR_MD] <= 1'b1;
        status_register_r[cxa_pkg::SR_RB] <= 1'b1;
        branch_r                   <= 1'b1;
        branch_pc_r                <= vector_base_register_r
                                      + cxa_pkg::INT_OFFSET; // [RULE5]
        pc_r                       <= vector_base_register_r
                                      + cxa_pkg::INT_OFFSET;
      end else if (rte_in) begin
        // return: restore sr and branch to spc [RULE17]
        status_register_r <= saved_status_register_r;
        branch_r          <= 1'b1;
        branch_pc_r       <= saved_program_counter_r;
        pc_r              <= saved_program_counter_r;
      end else if (reg_wr_in) begin
        // software writes; block bit set here before return [RULE18]
        case (reg_addr_in)
          cxa_pkg::A_SR:     status_register_r       <= reg_wdata_in;
          cxa_pkg::A_VBR:    vector_base_register_r  <= reg_wdata_in;
          cxa_pkg::A_SPC:    saved_program_counter_r <= reg_wdata_in;
          cxa_pkg::A_SSR:    saved_status_register_r <= reg_wdata_in;
          default: ;
        endcase
      end
    end
  end

  // software-only settings: dbr, control bits, interrupt levels
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      debug_base_register_r <= 32'h0000_0000;
      ctrl_r                <= 2'b00;
      prio_r                <= {cxa_pkg::NPER{cxa_pkg::PRIO_RESET}};
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        cxa_pkg::A_DBR:     debug_base_register_r <= reg_wdata_in;
        cxa_pkg::A_CTRL:    ctrl_r                <= reg_wdata_in[1:0];
        cxa_pkg::A_PRIO_LO: prio_r[31:0]          <= reg_wdata_in;
        cxa_pkg::A_PRIO_HI: prio_r[63:32]         <= reg_wdata_in;
        cxa_pkg::A_PRIO_X:  prio_r[67:64]         <= reg_wdata_in[3:0];
        default: ;
      endcase
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        cxa_pkg::A_SR:      reg_rdata_r <= status_register_r;
        cxa_pkg::A_VBR:     reg_rdata_r <= vector_base_register_r;
        cxa_pkg::A_SPC:     reg_rdata_r <= saved_program_counter_r;
        cxa_pkg::A_SSR:     reg_rdata_r <= saved_status_register_r;
        cxa_pkg::A_EXCEPTION_EVENT_REGISTER:  reg_rdata_r <= {20'h0,
                                            exception_event_register_r};
        cxa_pkg::A_INTERRUPT_EVENT_REGISTER:  reg_rdata_r <= {20'h0,
                                            interrupt_event_register_r};
        cxa_pkg::A_DBR:     reg_rdata_r <= debug_base_register_r;
        cxa_pkg::A_CTRL:    reg_rdata_r <= {30'h0, ctrl_r};
        cxa_pkg::A_PRIO_LO: reg_rdata_r <= prio_r[31:0];
        cxa_pkg::A_PRIO_HI: reg_rdata_r <= prio_r[63:32];
        cxa_pkg::A_PRIO_X:  reg_rdata_r <= {28'h0, prio_r[67:64]};
        cxa_pkg::A_PC:      reg_rdata_r <= pc_r;
        default:            reg_rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out       = reg_rdata_r;
  assign branch_out          = branch_r;
  assign branch_pc_out       = branch_pc_r;
  assign mrst_out            = mrst_r;
  assign status_register_out = status_register_r;
endmodule : cxa_unit

/* rtl/cxa_pkg.sv */
// package: constants and types of the cpu exception acceptance block
package cxa_pkg;
  localparam int          AW            = 32;
  localparam int          CW            = 12;
  localparam logic [31:0] RESET_ADDR    = 32'ha000_0000;
  localparam logic [31:0] VBR_RESET     = 32'h0000_0000;
  localparam logic [31:0] UBRK_OFFSET   = 32'h0000_0100;
  localparam logic [31:0] GEN_OFFSET    = 32'h0000_0100;
  localparam logic [31:0] INT_OFFSET    = 32'h0000_0600;
  // exception codes written to the event registers
  localparam logic [11:0] CODE_POR      = 12'h000;
  localparam logic [11:0] CODE_MRST     = 12'h020;
  localparam logic [11:0] CODE_UBRK     = 12'h1e0;
  localparam logic [11:0] CODE_IRL_BASE = 12'h200;
  localparam logic [11:0] CODE_NMI      = 12'h1c0;
  // peripheral interrupt codes, source index 0..16
  localparam logic [11:0] CODE_DMA_TRANSFER_END_CH0    = 12'h640;
  localparam logic [11:0] CODE_DMA_TRANSFER_END_CH1    = 12'h660;
  localparam logic [11:0] CODE_DMA_TRANSFER_END_CH2    = 12'h680;
  localparam logic [11:0] CODE_DMA_TRANSFER_END_CH3    = 12'h6a0;
  localparam logic [11:0] CODE_DMA_ADDRESS_FAULT     = 12'h6c0;
  localparam logic [11:0] CODE_UERI     = 12'h700;
  localparam logic [11:0] CODE_URXI     = 12'h720;
  localparam logic [11:0] CODE_UBRI     = 12'h740;
  localparam logic [11:0] CODE_UTXI     = 12'h760;
  localparam logic [11:0] CODE_HSERR    = 12'ha00;
  localparam logic [11:0] CODE_HERR     = 12'hae0;
  localparam logic [11:0] CODE_HPDN     = 12'hac0;
  localparam logic [11:0] CODE_HPUP     = 12'haa0;
  localparam logic [11:0] CODE_HDMA0    = 12'ha80;
  localparam logic [11:0] CODE_HDMA1    = 12'ha60;
  localparam logic [11:0] CODE_HDMA2    = 12'ha40;
  localparam logic [11:0] CODE_HDMA3    = 12'ha20;
  localparam int          NPER          = 17;
  // status register field positions
  localparam int          SR_MD         = 30;
  localparam int          SR_RB         = 29;
  localparam int          SR_BL         = 28;
  localparam int          SR_FD         = 15;
  localparam int          SR_IMSK_LO    = 4;
  localparam logic [31:0] SR_RESET      = 32'h7000_00f0;
  // register addresses of the plain software port
  localparam logic [3:0]  A_SR          = 4'h0;
  localparam logic [3:0]  A_VBR         = 4'h1;
  localparam logic [3:0]  A_SPC         = 4'h2;
  localparam logic [3:0]  A_SSR         = 4'h3;
  localparam logic [3:0]  A_EXCEPTION_EVENT_REGISTER      = 4'h4;
  localparam logic [3:0]  A_INTERRUPT_EVENT_REGISTER      = 4'h5;
  localparam logic [3:0]  A_DBR         = 4'h6;
  localparam logic [3:0]  A_CTRL        = 4'h7;
  localparam logic [3:0]  A_PRIO_LO     = 4'h8;
  localparam logic [3:0]  A_PRIO_HI     = 4'h9;
  localparam logic [3:0]  A_PRIO_X      = 4'ha;
  localparam logic [3:0]  A_PC          = 4'hb;
  localparam int          CTRL_USER_BREAK_DEBUG_ENABLE     = 0;
  localparam int          CTRL_NMIBL    = 1;
  localparam logic [3:0]  PRIO_RESET    = 4'h4;
  typedef enum logic [1:0] {
    CXA_IDLE = 2'b00,
    CXA_TAKE = 2'b01
  } cxa_state_t;
endpackage : cxa_pkg

/* dv/cxa_unit_chk.sv */
// checker: port relations of the exception acceptance block
`timescale 1ns/1ps
module cxa_unit_chk #(
  parameter int NLVL = 16 // interrupt levels
) (
  input wire logic        clk_sys_in,            // cpu clock
  input wire logic        arst_n_in,             // reset, low
  input wire logic        mrst_req_in,           // manual reset request
  input wire logic        gen_exc_in,            // general exception
  input wire logic        ubrk_in,               // user break
  input wire logic        nmi_in,                // nonmaskable interrupt
  input wire logic [3:0]  ext_irq_level_pins_in, // external level
  input wire logic [16:0] periph_irq_in,         // peripheral sources
  input wire logic        rte_in,                // return executed
  input wire logic        branch_out,            // redirect pulse
  input wire logic [31:0] branch_pc_out,         // redirect target
  input wire logic        mrst_out,              // modules reset pulse
  input wire logic [31:0] status_register_out    // live sr
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // exception block bit and any exception, break, nmi, reset or return request this cycle
  wire logic bl_w = status_register_out[28];
  wire logic ev_w = gen_exc_in | ubrk_in | nmi_in | mrst_req_in | rte_in;

  property p_rst_go;
    mrst_req_in |=> mrst_out && branch_out && branch_pc_out == 32'ha000_0000;
  endproperty
  a_rst_go: assert property (p_rst_go)
    else $error("manual reset did not redirect to reset address");
  property p_bl_fault;
    gen_exc_in && bl_w |=> mrst_out && branch_pc_out == 32'ha000_0000;
  endproperty
  a_bl_fault: assert property (p_bl_fault)
    else $error("exception under block bit did not force reset");
  property p_rst_sr;
    mrst_req_in || (gen_exc_in && bl_w) |=>
      (status_register_out & 32'h7000_80f0) == 32'h7000_00f0;
  endproperty
  a_rst_sr: assert property (p_rst_sr)
    else $error("status not initialised on reset entry");
  property p_gen_take;
    gen_exc_in && !bl_w && !mrst_req_in |=> branch_out && bl_w && !mrst_out;
  endproperty
  a_gen_take: assert property (p_gen_take)
    else $error("general exception not accepted with block clear");
  property p_ubrk;
    ubrk_in && !gen_exc_in && !mrst_req_in |=> branch_out && !mrst_out;
  endproperty
  a_ubrk: assert property (p_ubrk)
    else $error("user break not taken as a plain branch");
  property p_rte;
    rte_in && bl_w && !(gen_exc_in || ubrk_in || nmi_in || mrst_req_in)
      |=> branch_out;
  endproperty
  a_rte: assert property (p_rte)
    else $error("return did not branch");
  property p_bl_hold;
    bl_w && !ev_w |=> !branch_out;
  endproperty
  a_bl_hold: assert property (p_bl_hold)
    else $error("interrupt accepted while block bit set");
  property p_quiet;
    !ev_w && periph_irq_in == 17'h0_0000 && ext_irq_level_pins_in == 4'hf
      |=> !branch_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("branch without any request");
  property p_pc_hold;
    !branch_out |-> $stable(branch_pc_out);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("branch target moved without a branch");
  c_gen: cover property (gen_exc_in && !bl_w ##1 branch_out);
  c_int: cover property (periph_irq_in != 17'h0_0000 ##1 branch_out);
  c_mrst: cover property (mrst_out);
endmodule : cxa_unit_chk

bind cxa_unit cxa_unit_chk #(.NLVL(NLVL)) u_chk (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .mrst_req_in(mrst_req_in), .gen_exc_in(gen_exc_in), .ubrk_in(ubrk_in),
  .nmi_in(nmi_in), .ext_irq_level_pins_in(ext_irq_level_pins_in),
  .periph_irq_in(periph_irq_in), .rte_in(rte_in), .branch_out(branch_out),
  .branch_pc_out(branch_pc_out), .mrst_out(mrst_out),
  .status_register_out(status_register_out));

/* dv/cxa_src_model.sv */
// peripheral interrupt source model: levels held until dropped
`timescale 1ns/1ps
module cxa_src_model (
  input  wire logic        clk_sys_in,     // cpu clock
  input  wire logic        arst_n_in,      // reset, low
  input  wire logic [16:0] raise_in,       // sources to raise
  input  wire logic [16:0] drop_in,        // sources the handler clears
  output logic      [16:0] periph_irq_out  // request levels
);
  // a source stays up until serviced, so it pends under the block bit
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      periph_irq_out <= 17'h0_0000;
    end else begin
      periph_irq_out <= (periph_irq_out | raise_in) & ~drop_in;
    end
  end
endmodule : cxa_src_model

/* dv/tb_cpu_exception_acceptance.sv */
// testbench: exception acceptance ranking, vectors, codes and return
`timescale 1ns/1ps
module tb_cpu_exception_acceptance;
  logic clk_sys_in, arst_n_in, mrst_req_in, gen_exc_in, ubrk_in, nmi_in;
  logic rte_in, reg_wr_in, reg_rd_in, branch_out, mrst_out;
  logic [11:0] gen_code_in;
  logic [31:0] gen_pc_in, cur_pc_in, reg_wdata_in, reg_rdata_out, d;
  logic [31:0] branch_pc_out, status_register_out;
  logic [3:0]  ext_irq_level_pins_in, reg_addr_in;
  logic [16:0] periph_irq, raise_r, drop_r;
  int          err_total, samples_checked;
  // peripheral codes by source index
  localparam logic [11:0] PCODE [17] = '{12'h640, 12'h660, 12'h680,
    12'h6a0, 12'h6c0, 12'h700, 12'h720, 12'h740, 12'h760, 12'ha00, 12'hae0,
    12'hac0, 12'haa0, 12'ha80, 12'ha60, 12'ha40, 12'ha20};

  cxa_unit #(.NLVL(16)) DUT (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .mrst_req_in(mrst_req_in), .gen_exc_in(gen_exc_in),
    .gen_code_in(gen_code_in), .gen_pc_in(gen_pc_in), .ubrk_in(ubrk_in),
    .nmi_in(nmi_in), .ext_irq_level_pins_in(ext_irq_level_pins_in),
    .periph_irq_in(periph_irq), .rte_in(rte_in), .cur_pc_in(cur_pc_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .branch_out(branch_out),
    .branch_pc_out(branch_pc_out), .mrst_out(mrst_out),
    .status_register_out(status_register_out));
  cxa_src_model u_src (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .raise_in(raise_r), .drop_in(drop_r), .periph_irq_out(periph_irq));

  // 25 mhz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // one-cycle register write, then one-cycle read with data a cycle later
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    reg_addr_in <= a; reg_wdata_in <= v; reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a; reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd
  // one-cycle event pulse: 0 general, 1 user break, 2 return, 3 reset
  task automatic fire(input int k);
    @(posedge clk_sys_in);
    case (k)
      0: gen_exc_in <= 1'b1;
      1: ubrk_in <= 1'b1;
      2: rte_in <= 1'b1;
      default: mrst_req_in <= 1'b1;
    endcase
    @(posedge clk_sys_in);
    {gen_exc_in, ubrk_in, rte_in, mrst_req_in} <= 4'h0;
    #1;
  endtask : fire
  // raise or drop one peripheral source through the model
  task automatic src(input int i, input bit up);
    @(posedge clk_sys_in);
    if (up) raise_r <= 17'h0_0001 << i;
    else drop_r <= 17'h0_0001 << i;
    @(posedge clk_sys_in);
    raise_r <= 17'h0_0000; drop_r <= 17'h0_0000;
  endtask : src
  // wait a bounded time for a redirect and compare its target
  task automatic wait_br(input logic [31:0] pc);
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_sys_in);
      #1;
      if (branch_out === 1'b1) break;
    end
    chk("branch_target", branch_out ? branch_pc_out : 32'hx, pc);
  endtask : wait_br
  task automatic t_general;
    rd(cxa_pkg::A_SR); chk("sr_reset", d, 32'h7000_00f0);
    rd(cxa_pkg::A_EXCEPTION_EVENT_REGISTER); chk("exception_event_register_reset", d, 32'h0);
    wr(cxa_pkg::A_VBR, 32'h0000_1000); wr(cxa_pkg::A_SR, 32'h6000_0000);
    gen_code_in <= 12'h180; gen_pc_in <= 32'h0000_0040;
    fire(0); chk("gen_pc", branch_pc_out, 32'h0000_1100);
    rd(cxa_pkg::A_EXCEPTION_EVENT_REGISTER); chk("gen_code", d, 32'h180);
    rd(cxa_pkg::A_SPC); chk("gen_spc", d, 32'h40);
    rd(cxa_pkg::A_SSR); chk("gen_ssr", d, 32'h6000_0000);
    fire(0); chk("bl_mrst", mrst_out, 32'h1);
    chk("bl_pc", branch_pc_out, 32'ha000_0000);
    rd(cxa_pkg::A_EXCEPTION_EVENT_REGISTER); chk("bl_code", d, 32'h020);
    rd(cxa_pkg::A_VBR); chk("bl_vbr", d, 32'h0);
    fire(3); chk("mrst_pc", branch_pc_out, 32'ha000_0000);
    $display("test general done");
  endtask : t_general
  task automatic t_periph;
    wr(cxa_pkg::A_VBR, 32'h0000_1000);
    for (int i = 0; i < 17; i++) begin
      src(i, 1'b1); wr(cxa_pkg::A_SR, 32'h6000_0000);
      wait_br(32'h0000_1600);
      rd(cxa_pkg::A_INTERRUPT_EVENT_REGISTER); chk("per_code", d, PCODE[i]);
      src(i, 1'b0);
    end
    $display("test peripheral done");
  endtask : t_periph
  task automatic t_prio_block;
    wr(cxa_pkg::A_PRIO_HI, 32'h0000_0050); src(0, 1'b1); src(9, 1'b1);
    repeat (4) begin
      @(posedge clk_sys_in);
      #1 chk("blocked", branch_out, 32'h0);
    end
    wr(cxa_pkg::A_SR, 32'h6000_0000); wait_br(32'h0000_1600);
    rd(cxa_pkg::A_INTERRUPT_EVENT_REGISTER); chk("prio_win", d, 32'ha00);
    src(9, 1'b0); wr(cxa_pkg::A_SR, 32'h6000_0000); wait_br(32'h0000_1600);
    rd(cxa_pkg::A_INTERRUPT_EVENT_REGISTER); chk("prio_next", d, 32'h640);
    src(0, 1'b0); wr(cxa_pkg::A_PRIO_HI, 32'h4444_4444);
    ext_irq_level_pins_in <= 4'h2; wr(cxa_pkg::A_SR, 32'h6000_0000);
    wait_br(32'h0000_1600);
    rd(cxa_pkg::A_INTERRUPT_EVENT_REGISTER); chk("ext_code", d, 32'h240);
    rd(cxa_pkg::A_SPC); chk("ext_spc", d, 32'h0000_0500);
    ext_irq_level_pins_in <= 4'hf;
    $display("test priority done");
  endtask : t_prio_block
  task automatic t_break_nmi_rte;
    wr(cxa_pkg::A_DBR, 32'h0000_8000); wr(cxa_pkg::A_CTRL, 32'h1);
    fire(1); chk("ubrk_dbr", branch_pc_out, 32'h0000_8000);
    wr(cxa_pkg::A_CTRL, 32'h0);
    fire(1); chk("ubrk_vbr", branch_pc_out, 32'h0000_1100);
    chk("ubrk_nomrst", mrst_out, 32'h0);
    nmi_in <= 1'b1;
    repeat (4) begin
      @(posedge clk_sys_in);
      #1 chk("nmi_pend", branch_out, 32'h0);
    end
    wr(cxa_pkg::A_CTRL, 32'h2); wait_br(32'h0000_1600);
    // drop the level at once so the accepted nmi is not taken twice
    nmi_in <= 1'b0;
    rd(cxa_pkg::A_INTERRUPT_EVENT_REGISTER); chk("nmi_code", d, 32'h1c0);
    // block stays set while spc and ssr are restored
    wr(cxa_pkg::A_SR, 32'h7000_00f0); wr(cxa_pkg::A_SPC, 32'h0000_2000);
    wr(cxa_pkg::A_SSR, 32'h4000_00f0);
    fire(2); chk("rte_pc", branch_pc_out, 32'h0000_2000);
    chk("rte_sr", status_register_out, 32'h4000_00f0);
    rd(cxa_pkg::A_PC); chk("rte_last_pc", d, 32'h0000_2000);
    $display("test break and return done");
  endtask : t_break_nmi_rte
  // watchdog against a hang
  initial begin
    repeat (6000) @(posedge clk_sys_in);
    err_total++;
    stop_test();
  end
  initial begin
    {arst_n_in, mrst_req_in, gen_exc_in, ubrk_in, nmi_in, rte_in} = 6'h00;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 38'h0;
    {gen_code_in, gen_pc_in, raise_r, drop_r} = 78'h0;
    ext_irq_level_pins_in = 4'hf; cur_pc_in = 32'h0000_0500;
    err_total = 0; samples_checked = 0;
    repeat (20) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    t_general(); t_periph(); t_prio_block(); t_break_nmi_rte();
    stop_test();
  end
endmodule : tb_cpu_exception_acceptance
